// [design/tc8_pkg.sv]
package tc8_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FORCE = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_CMP_A = 8'h0c;
    localparam logic [7:0] OFF_CMP_B = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_A_LSB = 4;
    localparam int CTRL_ACT_B_LSB = 6;
    localparam int CTRL_CS_LSB = 8;
    localparam int FORCE_A_BIT = 0;
    localparam int FORCE_B_BIT = 1;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_MA_BIT = 1;
    localparam int FLAG_MB_BIT = 2;

    // ------------------------------------------------------------
    // values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam logic [9:0] DIV_8 = 10'h007;
    localparam logic [9:0] DIV_64 = 10'h03f;
    localparam logic [9:0] DIV_256 = 10'h0ff;
    localparam logic [9:0] DIV_1024 = 10'h3ff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PHASE_FF = 3'h1,
        MODE_CLEAR_ON_MATCH = 3'h2,
        MODE_FAST_FF = 3'h3,
        MODE_RSV4 = 3'h4,
        MODE_PHASE_CA = 3'h5,
        MODE_RSV6 = 3'h6,
        MODE_FAST_CA = 3'h7
    } tc8_mode_t;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_RSV6 = 3'h6,
        CS_RSV7 = 3'h7
    } tc8_clk_sel_t;

    typedef struct packed {
        logic value;
        logic oe;
    } tc8_pin_t;

    typedef struct packed {
        logic value;
        logic ddr;
    } tc8_port_t;

endpackage

// [design/tc8_timer.sv]
// What this block does
// [R1] compare values double-buffered in PWM modes, direct in normal and clear modes
// [R2] buffered compare copied to active register only at top, while counting up
// [R3] force strobe in non-PWM modes applies action, no flag, counter untouched
// [R4] counter write blocks all compare matches in next timer cycle, even stopped
// [R5] software must not write counter equal to compare or bottom when counting down
// [R6] output states keep their values across mode changes
// [R7] action select unbuffered, applies at next match or via force strobe
// [R8] reset clears both output states to zero
// [R9] nonzero action select replaces port value; direction stays with port bit
// [R10] action select zero leaves output state unchanged on match
// [R11] normal mode counts up, wraps ff to 00, overflow flag set on zero
// [R12] hardware only sets overflow flag; software clears it
// [R13] mode 2 clears counter on match with compare value a
// [R14] compare a below count in mode 2: count runs through wrap first
// [R15] mode 2 action one toggles output a on each match
// [R16] mode 2 overflow flag set when counter passes max to 00; the code skips it when compare a is ff
// [R17] fast PWM single slope; mode 3 top ff, mode 7 top compare a
// [R18] fast PWM clears counter in the timer cycle after top match
// [R19] fast PWM action two clears on match sets at bottom; three inverse
// [R20] fast PWM action one toggles a only with top mode bit; not on b
// [R21] fast PWM overflow flag set each time counter reaches top
// [R22] fast PWM compare a at bottom spikes; at max output stays constant
// [R23] compare match sets its flag on the following timer cycle
// [R24] modes 1 and 5 are dual-slope phase-correct PWM
// [R25] reserved mode codes count as normal mode
//
// Implementation choices: the register addresses and the APB register port.
module tc8_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tc8_pkg::tc8_port_t port_a,
    input wire tc8_pkg::tc8_port_t port_b,
    output tc8_pkg::tc8_pin_t pin_a,
    output tc8_pkg::tc8_pin_t pin_b
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tc8_pkg::tc8_mode_t mode_q;
    tc8_pkg::tc8_clk_sel_t cs_q;
    logic [1:0] act_a_q, act_b_q;
    logic [7:0] cnt_q, cmp_a_buf_q, cmp_b_buf_q, cmp_a_q, cmp_b_q;
    logic down_q, block_q, ovf_q, flag_a_q, flag_b_q, out_a_q, out_b_q, tick, addr_ok;
    logic [9:0] pre_q;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------
    logic acc, wr, is_pwm, is_fast, is_phase, is_ctc, at_top, hit_a, hit_b, fa, fb;
    logic [7:0] top;

    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    always_comb
    begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            tc8_pkg::OFF_CTRL:
            begin
                rdata_d[tc8_pkg::CTRL_MODE_LSB +: 3] = mode_q;
                rdata_d[tc8_pkg::CTRL_ACT_A_LSB +: 2] = act_a_q;
                rdata_d[tc8_pkg::CTRL_ACT_B_LSB +: 2] = act_b_q;
                rdata_d[tc8_pkg::CTRL_CS_LSB +: 3] = cs_q;
            end
            tc8_pkg::OFF_FORCE: rdata_d = 32'h0000_0000;
            tc8_pkg::OFF_COUNT: rdata_d[7:0] = cnt_q;
            tc8_pkg::OFF_CMP_A: rdata_d[7:0] = cmp_a_buf_q;
            tc8_pkg::OFF_CMP_B: rdata_d[7:0] = cmp_b_buf_q;
            tc8_pkg::OFF_FLAGS:
            begin
                rdata_d[tc8_pkg::FLAG_OVF_BIT] = ovf_q;
                rdata_d[tc8_pkg::FLAG_MA_BIT] = flag_a_q;
                rdata_d[tc8_pkg::FLAG_MB_BIT] = flag_b_q;
            end
            tc8_pkg::OFF_STATUS: rdata_d[2:0] = {down_q, out_b_q, out_a_q};
            default: addr_ok = 1'b0;
        endcase
    end

    // one wait state: ready and read data both come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rdata_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= tc8_pkg::MODE_NORMAL;
            cs_q <= tc8_pkg::CS_STOP;
            act_a_q <= tc8_pkg::ACT_NONE;
            act_b_q <= tc8_pkg::ACT_NONE;
        end
        else if (wr && paddr == tc8_pkg::OFF_CTRL)
        begin
            mode_q <= tc8_pkg::tc8_mode_t'(pwdata[tc8_pkg::CTRL_MODE_LSB +: 3]);
            cs_q <= tc8_pkg::tc8_clk_sel_t'(pwdata[tc8_pkg::CTRL_CS_LSB +: 3]);
            act_a_q <= pwdata[tc8_pkg::CTRL_ACT_A_LSB +: 2]; // R7
            act_b_q <= pwdata[tc8_pkg::CTRL_ACT_B_LSB +: 2]; // R7
        end
    end

    // ------------------------------------------------------------
    // prescaler: one-cycle timer tick
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_q <= 10'h000;
        else if (cs_q == tc8_pkg::CS_STOP)
            pre_q <= 10'h000;
        else
            pre_q <= pre_q + 10'h001;
    end

    always_comb
    begin
        case (cs_q)
            tc8_pkg::CS_DIV1: tick = 1'b1;
            tc8_pkg::CS_DIV8: tick = (pre_q[2:0] == tc8_pkg::DIV_8[2:0]);
            tc8_pkg::CS_DIV64: tick = (pre_q[5:0] == tc8_pkg::DIV_64[5:0]);
            tc8_pkg::CS_DIV256: tick = (pre_q[7:0] == tc8_pkg::DIV_256[7:0]);
            tc8_pkg::CS_DIV1024: tick = (pre_q == tc8_pkg::DIV_1024);
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb
    begin
        is_fast = 1'b0;
        is_phase = 1'b0;
        is_ctc = 1'b0;
        top = tc8_pkg::CNT_MAX;
        case (mode_q)
            tc8_pkg::MODE_CLEAR_ON_MATCH:
            begin
                is_ctc = 1'b1; // R13
                top = cmp_a_q;
            end
            tc8_pkg::MODE_FAST_FF: is_fast = 1'b1; // R17
            tc8_pkg::MODE_FAST_CA:
            begin
                is_fast = 1'b1; // R17
                top = cmp_a_q;
            end
            tc8_pkg::MODE_PHASE_FF: is_phase = 1'b1; // R24
            tc8_pkg::MODE_PHASE_CA:
            begin
                is_phase = 1'b1; // R24
                top = cmp_a_q;
            end
            default: top = tc8_pkg::CNT_MAX; // R25
        endcase
    end

    assign is_pwm = is_fast || is_phase;
    assign at_top = (cnt_q == top);
    assign hit_a = tick && !block_q && (cnt_q == cmp_a_q); // R4
    assign hit_b = tick && !block_q && (cnt_q == cmp_b_q); // R4

    // ------------------------------------------------------------
    // counter and direction
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= tc8_pkg::RST_BYTE;
            down_q <= 1'b0;
        end
        else if (wr && paddr == tc8_pkg::OFF_COUNT)
            cnt_q <= pwdata[7:0];
        else if (tick)
        begin
            if (is_phase)
            begin
                if (!down_q && at_top)
                begin
                    down_q <= 1'b1; // R24
                    cnt_q <= cnt_q - 8'h01;
                end
                else if (down_q && cnt_q == tc8_pkg::CNT_BOTTOM)
                begin
                    down_q <= 1'b0;
                    cnt_q <= cnt_q + 8'h01;
                end
                else
                    cnt_q <= down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
            end
            else
            begin
                down_q <= 1'b0;
                if ((is_ctc || is_fast) && at_top)
                    cnt_q <= tc8_pkg::CNT_BOTTOM; // R13 R18
                else
                    cnt_q <= cnt_q + 8'h01; // R11 R14
            end
        end
    end

    // a counter write blocks matches until the next timer tick has passed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            block_q <= 1'b0;
        else if (wr && paddr == tc8_pkg::OFF_COUNT)
            block_q <= 1'b1; // R4
        else if (tick)
            block_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // compare values and their buffers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_buf_q <= tc8_pkg::RST_BYTE;
            cmp_b_buf_q <= tc8_pkg::RST_BYTE;
        end
        else if (wr)
        begin
            if (paddr == tc8_pkg::OFF_CMP_A)
                cmp_a_buf_q <= pwdata[7:0]; // R2
            if (paddr == tc8_pkg::OFF_CMP_B)
                cmp_b_buf_q <= pwdata[7:0]; // R2
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_q <= tc8_pkg::RST_BYTE;
            cmp_b_q <= tc8_pkg::RST_BYTE;
        end
        else if (!is_pwm)
        begin
            if (wr && paddr == tc8_pkg::OFF_CMP_A)
                cmp_a_q <= pwdata[7:0]; // R1
            if (wr && paddr == tc8_pkg::OFF_CMP_B)
                cmp_b_q <= pwdata[7:0]; // R1
        end
        else if (tick && at_top && !down_q)
        begin
            cmp_a_q <= cmp_a_buf_q; // R1 R2
            cmp_b_q <= cmp_b_buf_q; // R1 R2
        end
    end

    // ------------------------------------------------------------
    // flags: set wins over a write-one clear
    // ------------------------------------------------------------
    logic ovf_set, clr;
    always_comb
    begin
        ovf_set = 1'b0;
        if (tick)
        begin
            if (is_fast)
                ovf_set = at_top; // R21
            else if (is_phase)
                ovf_set = down_q && cnt_q == 8'h01;
            else if (is_ctc)
                ovf_set = (cnt_q == tc8_pkg::CNT_MAX) && !at_top; // R16
            else
                ovf_set = (cnt_q == tc8_pkg::CNT_MAX); // R11
        end
    end
    assign clr = wr && paddr == tc8_pkg::OFF_FLAGS;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovf_q <= 1'b0;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end
        else
        begin
            if (ovf_set)
                ovf_q <= 1'b1; // R12
            else if (clr && pwdata[tc8_pkg::FLAG_OVF_BIT])
                ovf_q <= 1'b0;
            if (hit_a)
                flag_a_q <= 1'b1; // R23
            else if (clr && pwdata[tc8_pkg::FLAG_MA_BIT])
                flag_a_q <= 1'b0;
            if (hit_b)
                flag_b_q <= 1'b1; // R23
            else if (clr && pwdata[tc8_pkg::FLAG_MB_BIT])
                flag_b_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // waveform output states
    // ------------------------------------------------------------
    function automatic logic next_out(input logic cur, input logic [1:0] act, input logic hit,
        input logic bottom_evt, input logic up, input logic fast, input logic phase,
        input logic toggle_ok);
        logic r;
        r = cur;
        if (fast)
        begin
            if (bottom_evt && act[1])
                r = (act == tc8_pkg::ACT_CLEAR); // R19 R22
            else if (hit && act[1])
                r = (act == tc8_pkg::ACT_SET); // R19
            else if (hit && act == tc8_pkg::ACT_TOGGLE && toggle_ok)
                r = !cur; // R20
        end
        else if (phase)
        begin
            if (hit && act[1])
                r = up ? (act == tc8_pkg::ACT_SET) : (act == tc8_pkg::ACT_CLEAR);
            else if (hit && act == tc8_pkg::ACT_TOGGLE && toggle_ok)
                r = !cur;
        end
        else if (hit)
        begin
            case (act)
                tc8_pkg::ACT_TOGGLE: r = !cur; // R15
                tc8_pkg::ACT_CLEAR: r = 1'b0;
                tc8_pkg::ACT_SET: r = 1'b1;
                default: r = cur; // R10
            endcase
        end
        return r;
    endfunction
    logic force_wr, bottom_evt;
    assign force_wr = wr && paddr == tc8_pkg::OFF_FORCE && !is_pwm; // R3
    assign bottom_evt = tick && is_fast && at_top;
    assign fa = force_wr && pwdata[tc8_pkg::FORCE_A_BIT];
    assign fb = force_wr && pwdata[tc8_pkg::FORCE_B_BIT];
    // mode changes never touch these flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_a_q <= 1'b0; // R8
            out_b_q <= 1'b0; // R8
        end
        else
        begin
            out_a_q <= next_out(out_a_q, act_a_q, hit_a || fa, bottom_evt, !down_q,
                                is_fast, is_phase, mode_q[2]); // R6 R20
            out_b_q <= next_out(out_b_q, act_b_q, hit_b || fb, bottom_evt, !down_q,
                                is_fast, is_phase, 1'b0); // R6 R20
        end
    end

    // ------------------------------------------------------------
    // port pin override
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_a <= '0;
            pin_b <= '0;
        end
        else
        begin
            pin_a.value <= (act_a_q != tc8_pkg::ACT_NONE) ? out_a_q : port_a.value; // R9
            pin_a.oe <= port_a.ddr; // R9
            pin_b.value <= (act_b_q != tc8_pkg::ACT_NONE) ? out_b_q : port_b.value; // R9
            pin_b.oe <= port_b.ddr; // R9
        end
    end

endmodule

// [tb/tc8_timer_properties.sv]
module tc8_timer_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tc8_pkg::tc8_port_t port_a,
    input wire tc8_pkg::tc8_port_t port_b,
    input wire tc8_pkg::tc8_pin_t pin_a,
    input wire tc8_pkg::tc8_pin_t pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // channel a action as last written over the bus
    // ------------------------------------------------------------
    logic [1:0] act_a_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            act_a_q <= 2'h0;
        else if (psel && penable && pready && pwrite && paddr == tc8_pkg::OFF_CTRL)
            act_a_q <= pwdata[5:4];
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    access_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_qualified_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answer");
    unmapped_err_a: assert property (pready && paddr > tc8_pkg::OFF_STATUS |-> pslverr)
        else $error("unmapped access not refused");
    idle_read_zero_a: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("prdata not zero outside read answer");
    force_read_zero_a: assert property (pready && !pwrite && paddr == tc8_pkg::OFF_FORCE
        |-> prdata == 32'h0)
        else $error("force register read not zero");
    oe_follow_a: assert property (port_a.ddr |=> pin_a.oe)
        else $error("pin a enable not following direction");
    oe_drop_a: assert property (!port_b.ddr |=> !pin_b.oe)
        else $error("pin b driven while direction is input");
    port_pass_a: assert property (act_a_q == 2'h0 |=> pin_a.value == $past(port_a.value))
        else $error("pin a not showing port value");
    reset_pin_low_a: assert property ($rose(presetn) |-> !pin_a.value && !pin_b.value)
        else $error("pin value not low after reset");
endmodule

bind tc8_timer tc8_timer_properties tc8_timer_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a(port_a), .port_b(port_b), .pin_a(pin_a), .pin_b(pin_b));

// [tb/tc8_gpio_model.sv]
module tc8_gpio_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] set_value,
    input wire logic [1:0] set_ddr,
    output tc8_pkg::tc8_port_t port_a,
    output tc8_pkg::tc8_port_t port_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // port data and direction registers, cleared by system reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a <= '0;
            port_b <= '0;
        end
        else
        begin
            port_a <= '{value: set_value[0], ddr: set_ddr[0]};
            port_b <= '{value: set_value[1], ddr: set_ddr[1]};
        end
    end
endmodule

// [tb/tc8_timer_tb_top.sv]
`define CHK(nm, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module tc8_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] cnt;
        logic [2:0] flags;
        logic [1:0] outs;
        logic [7:0] cmax;
    } tc8_row_t;
    tc8_row_t rows [10] = '{
        '{3'h0, 2'h1, 2'h3, 8'h05, 8'h07, 8'hfe, 3'h7, 2'h3, 8'h20},
        '{3'h2, 2'h3, 2'h0, 8'h03, 8'h02, 8'h00, 3'h6, 2'h1, 8'h03},
        '{3'h2, 2'h1, 2'h3, 8'h10, 8'h28, 8'h20, 3'h4, 2'h2, 8'h40},
        '{3'h3, 2'h2, 2'h3, 8'h80, 8'h05, 8'hfe, 3'h5, 2'h3, 8'h20},
        '{3'h7, 2'h3, 2'h1, 8'h05, 8'h02, 8'h00, 3'h7, 2'h0, 8'h05},
        '{3'h3, 2'h1, 2'h0, 8'h05, 8'h06, 8'h00, 3'h6, 2'h0, 8'h20},
        '{3'h4, 2'h0, 2'h3, 8'h05, 8'h03, 8'hfe, 3'h7, 2'h2, 8'h20},
        '{3'h6, 2'h2, 2'h1, 8'h02, 8'h04, 8'hfe, 3'h7, 2'h2, 8'h20},
        '{3'h5, 2'h0, 2'h3, 8'h05, 8'h02, 8'h00, 3'h7, 2'h2, 8'h05},
        '{3'h2, 2'h1, 2'h0, 8'h05, 8'h06, 8'hfe, 3'h3, 2'h1, 8'h05}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] set_value = 2'h0;
    logic [1:0] set_ddr = 2'h0;
    tc8_pkg::tc8_port_t port_a;
    tc8_pkg::tc8_port_t port_b;
    tc8_pkg::tc8_pin_t pin_a;
    tc8_pkg::tc8_pin_t pin_b;
    logic [31:0] rdat;
    logic rerr;
    int fail_count = 0;
    int cmp_count = 0;

    always #2.5 pclk = ~pclk;

    tc8_gpio_model tc8_gpio_model_inst (.pclk(pclk), .presetn(presetn), .set_value(set_value),
        .set_ddr(set_ddr), .port_a(port_a), .port_b(port_b));
    tc8_timer tc8_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a(port_a), .port_b(port_b), .pin_a(pin_a), .pin_b(pin_b));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wctl(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] ab,
        input logic [2:0] cs);
        wr(tc8_pkg::OFF_CTRL, {21'h0, cs, ab, aa, 1'b0, m});
    endtask

    task automatic run(input int n, input logic [2:0] m, input logic [1:0] aa,
        input logic [1:0] ab);
        wr(tc8_pkg::OFF_FLAGS, 32'h7);
        wctl(m, aa, ab, 3'h1);
        repeat (n) @(posedge pclk);
        wctl(m, aa, ab, 3'h0);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        set_ddr <= 2'h3;
        foreach (rows[i])
        begin
            wctl(3'h0, 2'h2, 2'h2, 3'h0);
            wr(tc8_pkg::OFF_FORCE, 32'h3);
            wr(tc8_pkg::OFF_CMP_A, {24'h0, rows[i].cmp_a});
            wr(tc8_pkg::OFF_CMP_B, {24'h0, rows[i].cmp_b});
            wr(tc8_pkg::OFF_COUNT, {24'h0, rows[i].cnt});
            run(20, rows[i].mode, rows[i].act_a, rows[i].act_b);
            rd(tc8_pkg::OFF_FLAGS);
            `CHK("flags", rows[i].flags, rdat[2:0])
            rd(tc8_pkg::OFF_STATUS);
            `CHK("outs", rows[i].outs, rdat[1:0])
            rd(tc8_pkg::OFF_COUNT);
            `CHK("count", 1'b1, rdat[7:0] <= rows[i].cmax)
            $display("row %0d done", i);
        end
        rd(8'h1c);
        `CHK("unmapped", 33'h100000000, {rerr, rdat})
        rd(tc8_pkg::OFF_FORCE);
        `CHK("force_read", 32'h0, rdat)
        $display("bus test done");
        wctl(3'h0, 2'h0, 2'h0, 3'h0);
        set_value <= 2'h3;
        wr(tc8_pkg::OFF_CMP_A, 32'h10);
        wr(tc8_pkg::OFF_CMP_B, 32'h10);
        wr(tc8_pkg::OFF_COUNT, 32'h10);
        run(10, 3'h0, 2'h0, 2'h0);
        rd(tc8_pkg::OFF_FLAGS);
        `CHK("blocked", 3'h0, rdat[2:0])
        `CHK("pin_pass", 2'h3, {pin_b.value, pin_a.value})
        wr(tc8_pkg::OFF_COUNT, 32'hff);
        run(6, 3'h0, 2'h0, 2'h0);
        wr(tc8_pkg::OFF_FLAGS, 32'h0);
        repeat (10) @(posedge pclk);
        rd(tc8_pkg::OFF_FLAGS);
        `CHK("ovf_held", 1'b1, rdat[0])
        wr(tc8_pkg::OFF_FLAGS, 32'h1);
        rd(tc8_pkg::OFF_FLAGS);
        `CHK("ovf_clear", 1'b0, rdat[0])
        $display("block test done");
        set_value <= 2'h0;
        wctl(3'h0, 2'h2, 2'h2, 3'h0);
        wr(tc8_pkg::OFF_FORCE, 32'h3);
        wr(tc8_pkg::OFF_COUNT, 32'h42);
        wr(tc8_pkg::OFF_FLAGS, 32'h7);
        wctl(3'h3, 2'h3, 2'h3, 3'h0);
        wr(tc8_pkg::OFF_FORCE, 32'h3);
        rd(tc8_pkg::OFF_STATUS);
        `CHK("force_pwm", 2'h0, rdat[1:0])
        wctl(3'h0, 2'h3, 2'h3, 3'h0);
        wr(tc8_pkg::OFF_FORCE, 32'h3);
        wctl(3'h3, 2'h3, 2'h3, 3'h0);
        rd(tc8_pkg::OFF_STATUS);
        `CHK("retain", 2'h3, rdat[1:0])
        rd(tc8_pkg::OFF_FLAGS);
        `CHK("force_flag", 3'h0, rdat[2:0])
        rd(tc8_pkg::OFF_COUNT);
        `CHK("force_count", 8'h42, rdat[7:0])
        `CHK("pin_override", 2'h3, {pin_b.value, pin_a.value})
        set_ddr <= 2'h0;
        repeat (3) @(posedge pclk);
        `CHK("pin_oe", 2'h0, {pin_b.oe, pin_a.oe})
        set_ddr <= 2'h3;
        $display("force test done");
        wctl(3'h0, 2'h0, 2'h0, 3'h0);
        wr(tc8_pkg::OFF_CMP_A, 32'h05);
        wr(tc8_pkg::OFF_COUNT, 32'h00);
        wctl(3'h7, 2'h0, 2'h0, 3'h0);
        wr(tc8_pkg::OFF_CMP_A, 32'h40);
        rd(tc8_pkg::OFF_CMP_A);
        `CHK("buffer_read", 8'h40, rdat[7:0])
        run(30, 3'h7, 2'h0, 2'h0);
        rd(tc8_pkg::OFF_FLAGS);
        `CHK("old_top", 1'b1, rdat[0])
        rd(tc8_pkg::OFF_COUNT);
        `CHK("new_top", 1'b1, rdat[7:0] > 8'h05 && rdat[7:0] < 8'h40)
        $display("buffer test done");
        wctl(3'h0, 2'h3, 2'h3, 3'h1);
        wr(tc8_pkg::OFF_FORCE, 32'h3);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(tc8_pkg::OFF_STATUS);
        `CHK("reset_out", 3'h0, rdat[2:0])
        rd(tc8_pkg::OFF_CTRL);
        `CHK("reset_ctrl", 32'h0, rdat)
        rd(tc8_pkg::OFF_COUNT);
        `CHK("reset_count", 32'h0, rdat)
        $display("reset test done");
        end_of_test();
    end
endmodule
